// File: verilog/urxbf_top.sv
// urxbf_top: serial receiver front end, two-entry receive buffer with per-frame flags, apb slave.
// assumes the serial line is synchronous to mclk_i and an apb master on the same clock.
`timescale 1ns/100ps
module urxbf_top (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [urxbf_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial line and pin control
    input wire logic rxd_i,
    output logic rxd_override_o,
    // interrupt
    input wire logic global_irq_en_i,
    output logic rx_irq_o
);
    import urxbf_pkg::*;

    // majority of three samples, used by voting and the assertions
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0] ctb_q; // receiver enable, irq enable
    logic [7:0] ctc_q; // parity, stop count, char size
    logic dspd_q; // double speed select
    logic [11:0] baud_q; // sample tick divisor
    logic [11:0] div_q; // divider counter
    logic pready_q; // apb answer
    logic pslverr_q; // apb error
    logic [31:0] prdata_q; // latched read data
    urxbf_state_e st_q; // receive state
    logic [4:0] smp_q; // sample number inside a bit
    logic [2:0] bit_q; // data bit index
    logic [2:0] vote_q; // centre samples
    logic prev_q; // line level at previous tick
    logic [7:0] shf_q; // character being assembled
    logic fe_q; // stop bit status of assembled frame
    logic pbit_q; // received parity bit
    logic par_en_q; // parity enable captured at frame start
    logic [ENT_W-1:0] hold_q; // finished frame waiting for room
    logic hold_v_q; // hold register occupied
    logic dor_pend_q; // frames lost since last transfer
    logic [ENT_W-1:0] buf_q [BUF_DEPTH]; // receive buffer
    logic wr_q; // write pointer
    logic rd_q; // read pointer
    logic [1:0] cnt_q; // stored entries

    ////////////////////////////////////////////////////////////////////////////
    // decoding and selection
    wire rx_on = ctb_q[CTB_RXON];
    wire irq_on = ctb_q[CTB_IRQEN];
    wire par_on = ctc_q[CTC_PAREN];
    wire par_odd = ctc_q[CTC_PARODD];
    wire [2:0] nbits = MIN_CHAR + {1'b0, ctc_q[CTC_SZ_LO+1:CTC_SZ_LO]};
    wire [4:0] smp_n = dspd_q ? SMP_DBL : SMP_NORM;
    wire [4:0] smp_mid = dspd_q ? MID_DBL : MID_NORM;
    wire tick = (div_q == 12'h000);
    wire [2:0] vset = {vote_q[1:0], rxd_i};
    // smp_q trails the sample number by one, so the vote closes on the last centre sample
    wire decide = tick && (smp_q == smp_mid);
    wire voted = maj3(vset);
    wire bit_end = tick && (smp_q == smp_n);
    wire start_edge = tick && rx_on && (st_q == URXBF_IDLE) && prev_q && !rxd_i;
    wire start_ok = decide && (st_q == URXBF_START) && !voted;
    wire frame_done = decide && (st_q == URXBF_STOP);
    wire last_bit = (bit_q == nbits - 3'h1);
    wire par_bad = par_en_q && ((^shf_q ^ pbit_q) != par_odd);
    wire [ENT_W-1:0] new_ent = {par_bad, 1'b0, !voted, shf_q};
    wire acc = psel_i && penable_i && pready_q;
    wire rd_data = acc && !pwrite_i && (paddr_i == OFS_DATA);
    wire wr_en = acc && pwrite_i;
    wire rxc = (cnt_q != 2'h0);
    wire pop = rd_data && rxc;
    wire full = (cnt_q == 2'(BUF_DEPTH));
    wire room = !full || pop;
    wire push = hold_v_q && room;
    wire overrun = start_edge && full && hold_v_q;
    wire [ENT_W-1:0] head = rxc ? buf_q[rd_q] : '0;
    wire [7:0] sta_rd = {rxc, 2'b00, head[ENT_FERR], head[ENT_OVR], head[ENT_PERR], dspd_q, 1'b0};
    wire mapped = (paddr_i == OFS_DATA) || (paddr_i == OFS_STA) || (paddr_i == OFS_CTB)
        || (paddr_i == OFS_CTC) || (paddr_i == OFS_BAUD);
    logic [31:0] rd_mux;

    // read multiplexer; the data word keeps unused upper bits at zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            OFS_DATA: rd_mux = {24'h000000, head[7:0]};
            OFS_STA: rd_mux = {24'h000000, sta_rd};
            OFS_CTB: rd_mux = {24'h000000, ctb_q};
            OFS_CTC: rd_mux = {24'h000000, ctc_q};
            OFS_BAUD: rd_mux = {20'h00000, baud_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait cycle, read data latched before the completing edge
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // software registers; status write touches only the speed bit
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctb_q <= CTB_RST;
            ctc_q <= CTC_RST;
            dspd_q <= 1'b0;
            baud_q <= BAUD_RST;
        end else if (wr_en) begin
            if (paddr_i == OFS_CTB) begin
                ctb_q <= pwdata_i[7:0];
            end
            if (paddr_i == OFS_CTC) begin
                ctc_q <= pwdata_i[7:0];
            end
            if (paddr_i == OFS_STA) begin
                dspd_q <= pwdata_i[STA_DSPD];
            end
            if (paddr_i == OFS_BAUD) begin
                baud_q <= pwdata_i[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample tick divider; free-running, reloads from baud_q at each tick and while the receiver is off
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 12'h000;
        end else if (tick || !rx_on) begin
            div_q <= baud_q;
        end else begin
            div_q <= div_q - 12'h001;
        end
    end

    // receive state machine; disable drops any frame in progress
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= URXBF_IDLE;
            smp_q <= 5'h00;
            bit_q <= 3'h0;
            vote_q <= 3'h0;
            prev_q <= 1'b0;
            shf_q <= 8'h00;
            fe_q <= 1'b0;
            pbit_q <= 1'b0;
            par_en_q <= 1'b0;
        end else if (!rx_on) begin
            st_q <= URXBF_IDLE;
            smp_q <= 5'h00;
            prev_q <= 1'b0;
        end else if (tick) begin
            prev_q <= rxd_i;
            vote_q <= vset;
            smp_q <= bit_end ? 5'h01 : smp_q + 5'h01;
            unique case (st_q)
                URXBF_IDLE: begin
                    if (start_edge) begin
                        st_q <= URXBF_START;
                        smp_q <= 5'h01;
                        shf_q <= 8'h00;
                        par_en_q <= par_on;
                    end
                end
                URXBF_START: begin
                    if (decide && voted) begin
                        st_q <= URXBF_IDLE;
                    end else if (bit_end) begin
                        st_q <= URXBF_DATA;
                        bit_q <= 3'h0;
                    end
                end
                URXBF_DATA: begin
                    if (decide) begin
                        shf_q[bit_q] <= voted;
                    end
                    if (bit_end) begin
                        bit_q <= bit_q + 3'h1;
                        if (last_bit) begin
                            st_q <= par_en_q ? URXBF_PAR : URXBF_STOP;
                        end
                    end
                end
                URXBF_PAR: begin
                    if (decide) begin
                        pbit_q <= voted;
                    end
                    if (bit_end) begin
                        st_q <= URXBF_STOP;
                    end
                end
                URXBF_STOP: begin
                    if (decide) begin
                        fe_q <= !voted;
                        st_q <= URXBF_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift hold stage and lost-frame tracking; a new frame overwrites a waiting one
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_q <= '0;
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b0;
        end else if (!rx_on) begin
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b0;
        end else begin
            if (frame_done) begin
                hold_q <= new_ent;
                hold_v_q <= 1'b1;
            end else if (push) begin
                hold_v_q <= 1'b0;
            end
            // a loss in the transfer cycle still survives the clear
            dor_pend_q <= (dor_pend_q && !push) || overrun;
        end
    end

    // two-entry fifo; overrun is attached to the entry that follows the loss
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (!rx_on) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= !wr_q;
            end
            if (pop) begin
                rd_q <= !rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    // entry storage; no reset needed since the count guards every read
    genvar gi;
    generate
        for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_ent
            always_ff @(posedge mclk_i) begin
                if (push && (wr_q == 1'(gi))) begin
                    buf_q[gi] <= {hold_q[ENT_PERR], dor_pend_q, hold_q[ENT_FERR:0]};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // outputs: only the complete flag can request an interrupt
    assign rx_irq_o = irq_on && global_irq_en_i && rxc;
    assign rxd_override_o = rx_on;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_data_read;
        rd_data && rxc;
    endsequence

    sequence seq_disable;
        $fell(rx_on);
    endsequence

    AST_RXC_FILL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        push && !pop && rx_on |=> rxc && sta_rd[STA_RXC])
        else $error("complete flag not set after store");
    // the flush lands on the first edge that sees the enable low
    AST_FLUSH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        seq_disable |=> !rxc && st_q == URXBF_IDLE)
        else $error("disable did not flush buffer");
    // the flag must survive and the request must follow the global enable next cycle
    AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        irq_on && global_irq_en_i && rxc && rx_on && !rd_data && !wr_en |=> rxc && (rx_irq_o == global_irq_en_i))
        else $error("interrupt request dropped while flag set");
    AST_POP_LAST: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        seq_data_read ##0 (cnt_q == 2'h1 && !push && rx_on) |=> !rxc && !rx_irq_o)
        else $error("read of last entry did not clear flag");
    AST_NO_ERR_IRQ: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(rx_irq_o) |-> rxc && irq_on)
        else $error("interrupt without complete flag");
    AST_OVERRUN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        overrun && rx_on |=> dor_pend_q)
        else $error("overrun not recorded");
    AST_DOR_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        push && !overrun && rx_on |=> !dor_pend_q)
        else $error("overrun not cleared by transfer");
    AST_PAR_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        frame_done && !par_en_q && rx_on |=> !hold_q[ENT_PERR])
        else $error("parity error without parity enabled");
    AST_NOISE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_q == URXBF_START && decide && voted && rx_on |=> st_q == URXBF_IDLE)
        else $error("noise start bit accepted");
    // a frame finishing in the read cycle refills the hold stage, so it is left out
    AST_ROOM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        seq_data_read ##0 (full && hold_v_q && rx_on && !frame_done) |=> full && !hold_v_q)
        else $error("freed slot not refilled at once");
    AST_MASK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        frame_done && nbits == 3'h5 |-> shf_q[7:5] == 3'b000)
        else $error("unused data bits not zero");

endmodule : urxbf_top

// File: verilog/urxbf_pkg.sv
// urxbf_pkg: constants, register map, field layout and state type for the receive buffer block.
// assumes one 250 MHz system clock, APB register access and an 8-bit data path with a 5..8 bit character.
//
// Notes on behaviour
// - complete flag set while buffer unread
// - disabling receiver empties the buffer
// - level interrupt while flag and enables set
// - data read pops oldest character
// - error flags stored per buffer entry
// - writes to error flag bits ignored
// - error flags never raise interrupts
// - frame error shows first stop bit
// - only first stop bit is checked
// - overrun on full buffer, waiting character, start
// - overrun flag cleared by successful transfer
// - parity error zero when checking disabled
// - parity enable and odd/even select
// - parity compared, result stored in entry
// - parity flag uses enable at reception
// - disabling receiver aborts reception immediately
// - disabled receiver releases the input pin
// - read frees buffer location at once
// - clock and data recovery with filtering
// - sixteen or eight samples per bit
// - start bit voted on centre samples
// - every bit majority of centre samples
// - unused upper data bits read zero
package urxbf_pkg;

    // apb address width and register offsets (byte addresses)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_DATA = 12'h000;
    localparam logic [11:0] OFS_STA = 12'h004;
    localparam logic [11:0] OFS_CTB = 12'h008;
    localparam logic [11:0] OFS_CTC = 12'h00C;
    localparam logic [11:0] OFS_BAUD = 12'h010;

    // ctrl_status_a bit positions
    localparam int unsigned STA_RXC = 7;
    localparam int unsigned STA_FERR = 4;
    localparam int unsigned STA_OVR = 3;
    localparam int unsigned STA_PERR = 2;
    localparam int unsigned STA_DSPD = 1;
    // ctrl_status_b bit positions
    localparam int unsigned CTB_IRQEN = 7;
    localparam int unsigned CTB_RXON = 4;
    // ctrl_status_c bit positions
    localparam int unsigned CTC_PAREN = 5;
    localparam int unsigned CTC_PARODD = 4;
    localparam int unsigned CTC_STOP2 = 3;
    localparam int unsigned CTC_SZ_LO = 1;

    // reset values
    localparam logic [7:0] CTB_RST = 8'h00;
    localparam logic [7:0] CTC_RST = 8'h06;
    localparam logic [11:0] BAUD_RST = 12'h000;

    // buffer entry layout: data, then stop, overrun, parity status
    localparam int unsigned ENT_W = 11;
    localparam int unsigned ENT_FERR = 8;
    localparam int unsigned ENT_OVR = 9;
    localparam int unsigned ENT_PERR = 10;
    localparam int unsigned BUF_DEPTH = 2;

    // oversampling: samples per bit and centre sample
    localparam logic [4:0] SMP_NORM = 5'h10;
    localparam logic [4:0] SMP_DBL = 5'h08;
    localparam logic [4:0] MID_NORM = 5'h09;
    localparam logic [4:0] MID_DBL = 5'h05;
    localparam logic [2:0] MIN_CHAR = 3'h5;

    // receive state machine
    typedef enum logic [2:0] {
        URXBF_IDLE = 3'b000,
        URXBF_START = 3'b001,
        URXBF_DATA = 3'b010,
        URXBF_PAR = 3'b011,
        URXBF_STOP = 3'b100
    } urxbf_state_e;

endpackage : urxbf_pkg

// File: verif/urxbf_tx_model.sv
// urxbf_tx_model: remote asynchronous transmitter that drives the receive line.
// assumes a sample tick every clock (divisor 0), so one bit lasts spb clocks.
`timescale 1ns/100ps
module urxbf_tx_model (
    // clock
    input wire logic mclk_i,
    // serial line
    output logic rxd_o
);
    ////////////////////////////////////////
    // line idles high between frames
    initial rxd_o = 1'b1;

    // hold one level for a whole bit period
    task automatic put_bit(input logic v, input int spb);
        rxd_o <= v;
        repeat (spb) @(posedge mclk_i);
    endtask : put_bit

    // start, data lsb first, optional parity, one stop level, back to idle
    task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic podd,
                        input logic pbad, input logic stopv, input int spb);
        logic p; // parity bit, inverted on request to force a parity fault
        p = (^(d & ((8'h01 << nb) - 8'h01))) ^ podd ^ pbad;
        @(posedge mclk_i);
        put_bit(1'b0, spb);
        for (int i = 0; i < nb; i++) begin
            put_bit(d[i], spb);
        end
        if (pen) begin
            put_bit(p, spb);
        end
        put_bit(stopv, spb);
        rxd_o <= 1'b1;
    endtask : send

    // short low pulse that must not count as a start bit
    task automatic glitch(input int n);
        @(posedge mclk_i);
        rxd_o <= 1'b0;
        repeat (n) @(posedge mclk_i);
        rxd_o <= 1'b1;
    endtask : glitch
endmodule : urxbf_tx_model

// File: verif/urxbf_top_tb.sv
// urxbf_top_tb: self-checking bench for the receive buffer block.
// assumes apb at 250 MHz, baud divisor 0 and the transmitter model on the line.
`timescale 1ns/100ps
module urxbf_top_tb;
    import urxbf_pkg::*;
    ////////////////////////////////////////
    logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i, global_irq_en_i; // driven inputs
    logic [ADDR_W-1:0] paddr_i; // apb address
    logic [31:0] pwdata_i, prdata_o, rd, s; // apb data and scratch
    logic pready_o, pslverr_o, rxd_i, rxd_override_o, rx_irq_o, err; // outputs
    logic [31:0] rnd; // xorshift state
    logic [7:0] d; // character under test
    logic pen, podd, pbad, stopv, dspd, stop2; // frame settings
    int failures, num_checks, nb, n;
    localparam logic [31:0] CTB_ON = (32'h1 << CTB_IRQEN) | (32'h1 << CTB_RXON);
    localparam logic [11:0] RA [6] = '{OFS_DATA, OFS_STA, OFS_CTB, OFS_CTC, OFS_BAUD, 12'h020};
    localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'(CTB_RST), 32'(CTC_RST), 32'(BAUD_RST), 32'h0};

    urxbf_top urxbf_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .rxd_override_o(rxd_override_o),
        .global_irq_en_i(global_irq_en_i), .rx_irq_o(rx_irq_o));
    urxbf_tx_model urxbf_tx_model_inst (.mclk_i(mclk_i), .rxd_o(rxd_i));

    // free-running 4 ns clock
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////
    // verdict, the one place the run ends
    task automatic wrap_up();
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // xorshift stream, repeatable from its fixed start
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs

    // expected status word; flags belong to the buffer head
    function automatic logic [31:0] sta(input logic rxc, ferr, ovr, perr, dbl);
        return (32'(rxc) << STA_RXC) | (32'(ferr) << STA_FERR) | (32'(ovr) << STA_OVR) | (32'(perr) << STA_PERR)
            | (32'(dbl) << STA_DSPD);
    endfunction : sta

    // one apb transfer; request held until pready is seen at an edge, an idle cycle follows
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q,
                       output logic e);
        int k;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            failures++;
            wrap_up();
        end
        @(posedge mclk_i);
    endtask : apb

    // register write, and read with comparison
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, rd, err);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
    endtask : rc

    // poll for a finished character, bounded
    task automatic wait_rxc();
        n = 0;
        do begin
            apb(1'b0, OFS_STA, 32'h0, s, err);
            n++;
        end while (s[STA_RXC] !== 1'b1 && n < 10);
        if (s[STA_RXC] !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask : wait_rxc

    ////////////////////////////////////////
    // main sequence
    initial begin
        rnd = 32'h10;
        failures = 0;
        num_checks = 0;
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        global_irq_en_i = 1'b1;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        chk(32'(rxd_override_o), 32'h0);
        // reset values, then an unmapped place that must be refused
        for (int i = 0; i < 6; i++) begin
            rc(RA[i], RV[i]);
            chk(32'(err), 32'(i == 5));
        end
        wr(OFS_CTB, CTB_ON);
        chk(32'(rxd_override_o), 32'h1);
        // a three-clock low pulse fails the centre vote
        urxbf_tx_model_inst.glitch(3);
        repeat (40) @(posedge mclk_i);
        rc(OFS_STA, 32'h0);
        // random sizes, parity modes, faults and speeds; first four force each parity mode
        for (int k = 0; k < 16; k++) begin
            s = xs();
            {stop2, dspd, stopv, pbad, podd, pen} = {s[16:14], s[13] | s[12], s[11:10]};
            if (k < 4) begin
                {podd, pen} = 2'(k);
            end
            d = s[7:0];
            nb = 5 + int'(s[9:8]);
            wr(OFS_CTC, (32'(pen) << CTC_PAREN) | (32'(podd) << CTC_PARODD) | (32'(stop2) << CTC_STOP2)
                | (32'(nb - 5) << CTC_SZ_LO));
            wr(OFS_STA, 32'(dspd) << STA_DSPD);
            urxbf_tx_model_inst.send(d, nb, pen, podd, pbad, stopv, dspd ? 8 : 16);
            wait_rxc();
            rc(OFS_STA, sta(1'b1, ~stopv, 1'b0, pen & pbad, dspd));
            chk(32'(rx_irq_o), 32'h1);
            rc(OFS_DATA, {24'h0, d & ((8'h01 << nb) - 8'h01)});
            rc(OFS_STA, sta(1'b0, 1'b0, 1'b0, 1'b0, dspd));
        end
        wr(OFS_CTC, 32'(CTC_RST));
        wr(OFS_STA, 32'h0);
        // four frames unread: the third is lost and the fourth carries the overrun
        for (int k = 0; k < 4; k++) begin
            urxbf_tx_model_inst.send(8'hA0 + 8'(k), 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        end
        wr(OFS_STA, (32'h1 << STA_FERR) | (32'h1 << STA_OVR) | (32'h1 << STA_PERR));
        rc(OFS_STA, sta(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        rc(OFS_DATA, 32'hA0);
        rc(OFS_DATA, 32'hA1);
        rc(OFS_STA, sta(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
        rc(OFS_DATA, 32'hA3);
        // a clean frame clears the overrun; interrupt gated by both enables
        urxbf_tx_model_inst.send(8'h5A, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc();
        rc(OFS_STA, sta(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        global_irq_en_i <= 1'b0;
        @(posedge mclk_i);
        @(posedge mclk_i);
        chk(32'(rx_irq_o), 32'h0);
        global_irq_en_i <= 1'b1;
        wr(OFS_CTB, 32'h1 << CTB_RXON);
        chk(32'(rx_irq_o), 32'h0);
        wr(OFS_CTB, CTB_ON);
        // disable in mid-frame with a character still buffered
        fork
            urxbf_tx_model_inst.send(8'h33, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
            begin
                repeat (60) @(posedge mclk_i);
                wr(OFS_CTB, 32'h0);
            end
        join
        chk(32'(rxd_override_o), 32'h0);
        chk(32'(rx_irq_o), 32'h0);
        rc(OFS_STA, 32'h0);
        wr(OFS_CTB, CTB_ON);
        urxbf_tx_model_inst.send(8'hC3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        urxbf_tx_model_inst.send(8'h3C, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        rc(OFS_DATA, 32'hC3);
        // flush by reading data until the complete flag drops
        n = 0;
        apb(1'b0, OFS_STA, 32'h0, s, err);
        while (s[STA_RXC] === 1'b1 && n < 4) begin
            apb(1'b0, OFS_DATA, 32'h0, rd, err);
            n++;
            apb(1'b0, OFS_STA, 32'h0, s, err);
        end
        chk(32'(n), 32'h1);
        wrap_up();
    end
endmodule : urxbf_top_tb
